// *** core/vpsc_pkg.sv ***
package vpsc_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int              ADDR_W         = 8;
  localparam int              DATA_W         = 32;
  localparam logic [7:0]      OFS_CTRL       = 8'h00;
  localparam logic [7:0]      OFS_WINK_DELAY = 8'h04;
  localparam logic [7:0]      OFS_WINK_DUR   = 8'h08;
  localparam logic [7:0]      OFS_RX_GAIN    = 8'h0C;
  localparam logic [7:0]      OFS_TX_ATTEN   = 8'h10;
  localparam logic [7:0]      OFS_OPTIONS    = 8'h14;
  localparam logic [7:0]      OFS_STATUS     = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int              CTRL_EN_BIT    = 0;
  localparam int              CTRL_MODE_LSB  = 4;
  localparam int              CTRL_TYPE_LSB  = 8;
  localparam int              OPT_IMP_BIT    = 0;
  localparam int              OPT_RBACK_BIT  = 1;
  localparam int              OPT_COND_BIT   = 2;
  localparam int              STAT_NET_LSB   = 0;
  localparam int              STAT_WINK_LSB  = 2;
  localparam int              STAT_TONE_BIT  = 6;
  localparam int              STAT_ALARM_BIT = 7;

  // ----------------------------------------------------------------
  // Settings, limits and reset values (gains in 0.5 dB steps)
  // ----------------------------------------------------------------
  localparam logic [6:0]        WINK_MIN       = 7'h01;
  localparam logic [6:0]        WINK_MAX       = 7'h63;
  localparam logic [6:0]        WINK_DELAY_RST = 7'h0F;
  localparam logic [6:0]        WINK_DUR_RST   = 7'h14;
  localparam logic signed [5:0] RX_GAIN_MIN    = 6'h2C;
  localparam logic signed [5:0] RX_GAIN_MAX    = 6'h04;
  localparam logic signed [5:0] TX_ATTEN_MIN   = 6'h2C;
  localparam logic signed [5:0] TX_ATTEN_MAX   = 6'h0A;
  localparam logic signed [5:0] GAIN_RST       = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int              CLK_FREQ_HZ    = 20_000_000;
  localparam int              TICK_MS        = 10;
  localparam int              TICK_CYCLES    = CLK_FREQ_HZ / 1000 * TICK_MS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    STATION_SIDE_MODE         = 3'h0,
    STATION_SOFTNET_MODE      = 3'h1,
    STATION_SOFTNET_WINK_MODE = 3'h2,
    HOTLINE_RINGDOWN_MODE     = 3'h3,
    PULSE_ORIGINATING_MODE    = 3'h4
  } vpsc_mode_t;

  typedef enum logic [2:0] {
    SIG_LOOP_START          = 3'h0,
    SIG_LOOP_FWD_DISC       = 3'h1,
    SIG_GROUND_START        = 3'h2,
    SIG_GROUND_IMMEDIATE    = 3'h3,
    SIG_GROUND_AUTOMATIC    = 3'h4,
    RINGDOWN_LEGACY_VARIANT = 3'h5,
    RINGDOWN_MODERN_VARIANT = 3'h6
  } vpsc_sig_type_t;

  typedef struct packed {
    logic a;
    logic b;
  } vpsc_sig_t;

  typedef struct packed {
    logic              imp_900;
    logic              ringback_en;
    logic              cond_idle;
    logic signed [5:0] rx_gain;
    logic signed [5:0] tx_atten;
  } vpsc_cfg_t;

  localparam vpsc_sig_t SIG_ACTIVE = 2'h3;
  localparam vpsc_sig_t SIG_QUIET  = 2'h0;
  localparam vpsc_cfg_t CFG_RST    = {1'b0, 1'b0, 1'b0, GAIN_RST, GAIN_RST};

  function automatic logic type_valid(input logic [2:0] t, input vpsc_mode_t m);
    logic plain;
    logic softnet;
    plain   = (m == STATION_SIDE_MODE);
    softnet = plain || (m == STATION_SOFTNET_MODE) || (m == STATION_SOFTNET_WINK_MODE);
    unique case (t)
      3'h0, 3'h1, 3'h2: type_valid = softnet;
      3'h3, 3'h4:       type_valid = plain;
      3'h5, 3'h6:       type_valid = (m == HOTLINE_RINGDOWN_MODE);
      default:          type_valid = 1'b0;
    endcase
  endfunction : type_valid

  function automatic vpsc_sig_type_t first_valid(input vpsc_mode_t m);
    first_valid = (m == HOTLINE_RINGDOWN_MODE) ? RINGDOWN_LEGACY_VARIANT : SIG_LOOP_START;
  endfunction : first_valid

endpackage : vpsc_pkg

// *** core/vpsc_port_ctrl.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - Seven signaling types; loop start after reset.
// - Signaling type written only while enabled and not in pulse originating mode.
// - Mode change leaving type invalid forces first type valid in new mode.
// - Loop start, forward disconnect, ground start valid in station and softnet modes.
// - Immediate and automatic ground start valid only in plain station mode.
// - Legacy and modern ringdown variants valid only in hotline ringdown mode.
// - One-bit impedance select, 600 ohm default, applied only while enabled.
// - Wink delay 1..99 tens of ms, reset value 15.
// - Office off-hook starts delay, then wink toward network for duration.
// - Wink duration 1..99 tens of ms, reset value 20.
// - Wink timing acts only while enabled in the wink softnet mode.
// - Receive gain -10.0..+2.0 dB in half-dB steps, default 0.0.
// - Transmit attenuation -10.0..+5.0 dB in half-dB steps, default 0.0.
// - Ring-back tone per incoming call request when enabled; off after reset.
// - During carrier group alarm force trunk busy or idle; busy by default.
// - Options other than enable ignored while disabled; apply only once enabled.
// - Station mode sends two independent bits; softnet modes send equal bits.
module vpsc_port_ctrl #(
  parameter int TICK_CYCLES = vpsc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [vpsc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [vpsc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [vpsc_pkg::DATA_W-1:0] reg_rdata,
  // Trunk and station signaling
  input  wire logic                  office_offhook,
  input  wire vpsc_pkg::vpsc_sig_t   station_sig,
  input  wire logic                  carrier_group_alarm,
  input  wire logic                  call_request,
  output vpsc_pkg::vpsc_sig_t        net_sig,
  output logic                       wink_active,
  output logic                       ringback_tone,
  // Applied analog settings
  output vpsc_pkg::vpsc_cfg_t        port_cfg
);
  import vpsc_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------
  // Free-running 10 ms tick
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [TICK_W-1:0] tick_cnt_next;
  logic              tick_reg;
  logic              tick_next;

  always_comb begin
    tick_next     = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
    tick_cnt_next = tick_next ? '0 : tick_cnt_reg + TICK_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ----------------------------------------------------------------
  // Stored configuration
  // ----------------------------------------------------------------
  logic           enable_reg;
  logic           enable_next;
  vpsc_mode_t     mode_reg;
  vpsc_mode_t     mode_next;
  vpsc_sig_type_t type_reg;
  vpsc_sig_type_t type_next;
  logic [6:0]     dly_reg;
  logic [6:0]     dly_next;
  logic [6:0]     dur_reg;
  logic [6:0]     dur_next;
  vpsc_cfg_t      cfg_reg;
  vpsc_cfg_t      cfg_next;
  logic [2:0]        wr_mode;
  logic [2:0]        wr_type;
  logic [6:0]        wr_wink;
  logic signed [5:0] wr_gain;

  assign wr_mode = reg_wdata[CTRL_MODE_LSB +: 3];
  assign wr_type = reg_wdata[CTRL_TYPE_LSB +: 3];
  assign wr_wink = reg_wdata[6:0];
  assign wr_gain = reg_wdata[5:0];

  always_comb begin
    enable_next = enable_reg;
    mode_next   = mode_reg;
    type_next   = type_reg;
    dly_next    = dly_reg;
    dur_next    = dur_reg;
    cfg_next    = cfg_reg;
    if (reg_wr && reg_addr == OFS_CTRL) begin
      enable_next = reg_wdata[CTRL_EN_BIT];
      if (enable_reg && wr_mode <= 3'h4) begin
        mode_next = vpsc_mode_t'(wr_mode);
      end
      if (enable_reg && mode_next != PULSE_ORIGINATING_MODE && type_valid(wr_type, mode_next)) begin
        type_next = vpsc_sig_type_t'(wr_type);
      end
    end
    if (reg_wr && enable_reg) begin
      case (reg_addr)
        OFS_WINK_DELAY: if (wr_wink >= WINK_MIN && wr_wink <= WINK_MAX) dly_next = wr_wink;
        OFS_WINK_DUR:   if (wr_wink >= WINK_MIN && wr_wink <= WINK_MAX) dur_next = wr_wink;
        OFS_RX_GAIN:    if (wr_gain >= RX_GAIN_MIN && wr_gain <= RX_GAIN_MAX) begin
          cfg_next.rx_gain = wr_gain;
        end
        OFS_TX_ATTEN:   if (wr_gain >= TX_ATTEN_MIN && wr_gain <= TX_ATTEN_MAX) begin
          cfg_next.tx_atten = wr_gain;
        end
        OFS_OPTIONS: begin
          cfg_next.imp_900     = reg_wdata[OPT_IMP_BIT];
          cfg_next.ringback_en = reg_wdata[OPT_RBACK_BIT];
          cfg_next.cond_idle   = reg_wdata[OPT_COND_BIT];
        end
        default: ;
      endcase
    end
    if (mode_next != mode_reg && mode_next != PULSE_ORIGINATING_MODE
        && !type_valid(type_next, mode_next)) begin
      type_next = first_valid(mode_next);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      mode_reg   <= STATION_SIDE_MODE;
      type_reg   <= SIG_LOOP_START;
      dly_reg    <= WINK_DELAY_RST;
      dur_reg    <= WINK_DUR_RST;
      cfg_reg    <= CFG_RST;
    end else begin
      enable_reg <= enable_next;
      mode_reg   <= mode_next;
      type_reg   <= type_next;
      dly_reg    <= dly_next;
      dur_reg    <= dur_next;
      cfg_reg    <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Wink sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    WK_IDLE  = 4'h1,
    WK_DELAY = 4'h2,
    WK_PULSE = 4'h4,
    WK_HOLD  = 4'h8
  } vpsc_wink_st_t;

  vpsc_wink_st_t wk_reg;
  vpsc_wink_st_t wk_next;
  logic [6:0]    wk_cnt_reg;
  logic [6:0]    wk_cnt_next;
  logic          offhook_prev_reg;
  logic          wink_ok;

  assign wink_ok = enable_reg && mode_reg == STATION_SOFTNET_WINK_MODE && !carrier_group_alarm;

  always_comb begin
    wk_next     = wk_reg;
    wk_cnt_next = wk_cnt_reg;
    unique case (wk_reg)
      WK_IDLE: if (office_offhook && !offhook_prev_reg) begin
        wk_next     = WK_DELAY;
        wk_cnt_next = dly_reg;
      end
      WK_DELAY: if (tick_reg) begin
        if (wk_cnt_reg <= 7'h01) begin
          wk_next     = WK_PULSE;
          wk_cnt_next = dur_reg;
        end else begin
          wk_cnt_next = wk_cnt_reg - 7'h01;
        end
      end
      WK_PULSE: if (tick_reg) begin
        if (wk_cnt_reg <= 7'h01) begin
          wk_next = WK_HOLD;
        end else begin
          wk_cnt_next = wk_cnt_reg - 7'h01;
        end
      end
      WK_HOLD: if (!office_offhook) wk_next = WK_IDLE;
      default: wk_next = WK_IDLE;
    endcase
    if (!wink_ok) begin
      wk_next = WK_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wk_reg           <= WK_IDLE;
      wk_cnt_reg       <= 7'h00;
      offhook_prev_reg <= 1'b0;
    end else begin
      wk_reg           <= wk_next;
      wk_cnt_reg       <= wk_cnt_next;
      offhook_prev_reg <= office_offhook;
    end
  end

  // ----------------------------------------------------------------
  // Trunk outputs and applied settings
  // ----------------------------------------------------------------
  vpsc_sig_t net_next;
  logic      tone_next;
  vpsc_cfg_t port_cfg_next;

  always_comb begin
    if (!enable_reg) begin
      net_next = SIG_QUIET;
    end else if (carrier_group_alarm) begin
      net_next = cfg_reg.cond_idle ? SIG_QUIET : SIG_ACTIVE;
    end else if (wk_next == WK_PULSE) begin
      net_next = SIG_ACTIVE;
    end else if (mode_reg == STATION_SOFTNET_MODE || mode_reg == STATION_SOFTNET_WINK_MODE) begin
      net_next = {station_sig.a, station_sig.a};
    end else begin
      net_next = station_sig;
    end
    tone_next = enable_reg && cfg_reg.ringback_en && call_request && !carrier_group_alarm;
    port_cfg_next = enable_reg ? cfg_reg : CFG_RST;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      net_sig       <= SIG_QUIET;
      wink_active   <= 1'b0;
      ringback_tone <= 1'b0;
      port_cfg      <= CFG_RST;
    end else begin
      net_sig       <= net_next;
      wink_active   <= (wk_next == WK_PULSE);
      ringback_tone <= tone_next;
      port_cfg      <= port_cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: begin
          rdata_next[CTRL_EN_BIT]         = enable_reg;
          rdata_next[CTRL_MODE_LSB +: 3]  = mode_reg;
          rdata_next[CTRL_TYPE_LSB +: 3]  = type_reg;
        end
        OFS_WINK_DELAY: rdata_next[6:0] = dly_reg;
        OFS_WINK_DUR:   rdata_next[6:0] = dur_reg;
        OFS_RX_GAIN:    rdata_next[5:0] = cfg_reg.rx_gain;
        OFS_TX_ATTEN:   rdata_next[5:0] = cfg_reg.tx_atten;
        OFS_OPTIONS: begin
          rdata_next[OPT_IMP_BIT]   = cfg_reg.imp_900;
          rdata_next[OPT_RBACK_BIT] = cfg_reg.ringback_en;
          rdata_next[OPT_COND_BIT]  = cfg_reg.cond_idle;
        end
        OFS_STATUS: begin
          rdata_next[STAT_NET_LSB +: 2]  = net_sig;
          rdata_next[STAT_WINK_LSB +: 4] = wk_reg;
          rdata_next[STAT_TONE_BIT]      = ringback_tone;
          rdata_next[STAT_ALARM_BIT]     = carrier_group_alarm;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_defaults: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> type_reg == SIG_LOOP_START && dly_reg == 7'h0F && dur_reg == 7'h14
      && !ringback_tone && port_cfg == CFG_RST)
    else $error("reset values wrong");

  a_type_valid_mode: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    mode_reg != PULSE_ORIGINATING_MODE |-> type_valid(type_reg, mode_reg))
    else $error("signaling type invalid for mode");

  a_type_hold_pulse: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == PULSE_ORIGINATING_MODE || !enable_reg) ##1 mode_reg == $past(mode_reg)
      |-> $stable(type_reg))
    else $error("signaling type changed while locked");

  a_opts_disabled: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !enable_reg |=> $stable(cfg_reg) && $stable(dly_reg) && $stable(dur_reg))
    else $error("option changed while disabled");

  a_impedance_applied: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ##1 1'b1 |-> port_cfg.imp_900 == ($past(enable_reg) && $past(cfg_reg.imp_900)))
    else $error("impedance not applied per enable");

  a_wink_start: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wk_reg == WK_IDLE && wink_ok && office_offhook && !offhook_prev_reg
      |=> wk_reg == WK_DELAY && wk_cnt_reg == $past(dly_reg))
    else $error("wink delay not started");

  a_wink_mode_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !wink_ok |=> wk_reg == WK_IDLE && !wink_active)
    else $error("wink outside wink mode");

  a_wink_drives_net: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wink_active |-> net_sig == SIG_ACTIVE && wk_reg == WK_PULSE)
    else $error("wink not driven to network");

  a_alarm_cond: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    enable_reg && carrier_group_alarm
      |=> net_sig == ($past(cfg_reg.cond_idle) ? SIG_QUIET : SIG_ACTIVE))
    else $error("alarm conditioning wrong");

  a_two_state: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    enable_reg && !carrier_group_alarm && mode_reg == STATION_SOFTNET_MODE
      |=> net_sig.a == net_sig.b && net_sig.a == $past(station_sig.a))
    else $error("softnet bits differ");

  a_ringback_tone: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ##1 1'b1 |-> ringback_tone == ($past(enable_reg) && $past(cfg_reg.ringback_en)
      && $past(call_request) && !$past(carrier_group_alarm)))
    else $error("ring-back tone wrong");

  a_gain_range: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg_reg.rx_gain >= RX_GAIN_MIN && cfg_reg.rx_gain <= RX_GAIN_MAX
      && cfg_reg.tx_atten >= TX_ATTEN_MIN && cfg_reg.tx_atten <= TX_ATTEN_MAX)
    else $error("gain out of range");

endmodule : vpsc_port_ctrl

// *** dv/vpsc_far_end.sv ***
`timescale 1ns/1ps

module vpsc_far_end (
  // Clock
  input  wire logic ref_clk,
  // From the port
  input  wire logic wink_active,
  // Toward the port
  output logic      office_offhook,
  output logic      call_request,
  output logic      carrier_group_alarm
);

  initial begin
    office_offhook      = 1'b0;
    call_request        = 1'b0;
    carrier_group_alarm = 1'b0;
  end

  // Called at a rising edge only
  task automatic lines(input logic alarm, input logic call);
    carrier_group_alarm <= alarm;
    call_request        <= call;
  endtask : lines

  // Seize, time the wink, hold, then release
  task automatic seize(input int hold, output int dl, output int wd);
    dl = 0;
    wd = 0;
    @(posedge ref_clk);
    office_offhook <= 1'b1;
    while (wink_active !== 1'b1 && dl < 2000) begin
      @(posedge ref_clk);
      #1;
      dl++;
    end
    while (wink_active === 1'b1 && wd < 2000) begin
      @(posedge ref_clk);
      #1;
      wd++;
    end
    repeat (hold) @(posedge ref_clk);
    office_offhook <= 1'b0;
  endtask : seize

endmodule : vpsc_far_end

// *** dv/voice_port_signaling_control_tb_top.sv ***
`timescale 1ns/1ps

module voice_port_signaling_control_tb_top;
  import vpsc_pkg::*;

  localparam int T = 8;

  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        office_offhook;
  logic        carrier_group_alarm;
  logic        call_request;
  logic        wink_active;
  logic        ringback_tone;
  vpsc_sig_t   station_sig = 2'h0;
  vpsc_sig_t   net_sig;
  vpsc_cfg_t   port_cfg;
  logic [7:0]  r = 8'h62;
  int          miscompares = 0;
  int          checked = 0;
  int          en = 0, mode = 0, typ = 0, dly = 15, dur = 20, rx = 0, tx = 0, opt = 0;
  int          dl, wd;
  logic [31:0] sd;
  logic [1:0]  xn;
  int          wv[6] = '{0, 100, 1, 99, 0, 7};

  always #25 ref_clk = ~ref_clk;

  vpsc_port_ctrl #(.TICK_CYCLES(T)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .office_offhook(office_offhook), .station_sig(station_sig),
    .carrier_group_alarm(carrier_group_alarm), .call_request(call_request),
    .net_sig(net_sig), .wink_active(wink_active), .ringback_tone(ringback_tone),
    .port_cfg(port_cfg)
  );

  vpsc_far_end i_far (
    .ref_clk(ref_clk), .wink_active(wink_active), .office_offhook(office_offhook),
    .call_request(call_request), .carrier_group_alarm(carrier_group_alarm)
  );

  // ----------------------------------------------------------------
  // Model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  function automatic int ok_type(input int t, input int m);
    ok_type = (t <= 2) ? (m <= 2) : (t <= 4) ? (m == 0) : (t <= 6) ? (m == 3) : 0;
  endfunction : ok_type

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00:   exp_rd = en | (mode << 4) | (typ << 8);
      8'h04:   exp_rd = dly;
      8'h08:   exp_rd = dur;
      8'h0C:   exp_rd = rx & 63;
      8'h10:   exp_rd = tx & 63;
      8'h14:   exp_rd = opt;
      default: exp_rd = 32'h0;
    endcase
  endfunction : exp_rd

  function automatic logic [31:0] exp_cfg();
    logic [14:0] c;
    c = {opt[0], opt[1], opt[2], rx[5:0], tx[5:0]};
    exp_cfg = en ? {17'h0, c} : 32'h0;
  endfunction : exp_cfg

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int nm, t, s;
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    nm = d[6:4];
    t  = d[10:8];
    s  = $signed(d[5:0]);
    case (a)
      8'h00: begin
        if (en != 0) begin
          if (nm <= 4) mode = nm;
          if (mode != 4 && ok_type(t, mode) != 0) typ = t;
          else if (mode != 4 && ok_type(typ, mode) == 0) typ = (mode == 3) ? 5 : 0;
        end
        en = d[0];
      end
      8'h04: if (en != 0 && d[6:0] >= 1 && d[6:0] <= 99) dly = d[6:0];
      8'h08: if (en != 0 && d[6:0] >= 1 && d[6:0] <= 99) dur = d[6:0];
      8'h0C: if (en != 0 && s >= -20 && s <= 4) rx = s;
      8'h10: if (en != 0 && s >= -20 && s <= 10) tx = s;
      8'h14: if (en != 0) opt = d[2:0];
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic chk_regs();
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        rd(8'(i * 4), d);
        chk(d, exp_rd(8'(i * 4)));
      end
    end
    chk(port_cfg, exp_cfg());
  endtask : chk_regs

  task automatic finish_test();
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_regs();
    wr(8'h04, 32'h5);
    wr(8'h14, 32'h7);
    wr(8'h00, 32'h320);
    chk_regs();
    wr(8'h00, 32'h1);
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      wr(8'h00, {21'h0, 3'(r % 7), 1'b0, 3'(r[7:4] % 5), 4'h1});
      chk_regs();
    end
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      wr(8'h0C, {26'h0, r[5:0]});
      r = lfsr(r);
      wr(8'h10, {26'h0, r[5:0]});
      chk_regs();
    end
    foreach (wv[i]) begin
      wr(8'h04, wv[i]);
      wr(8'h08, wv[i] + 1);
      chk_regs();
    end
    for (int i = 0; i < 24; i++) begin
      r = lfsr(r);
      wr(8'h00, {21'h0, 3'(typ), 1'b0, 3'(i % 2), 4'h1});
      wr(8'h14, {29'h0, r[2:0]});
      @(posedge ref_clk);
      station_sig <= r[4:3];
      i_far.lines(r[5], r[6]);
      repeat (2) @(posedge ref_clk);
      #1;
      xn = !r[5] ? ((mode == 1) ? {r[4], r[4]} : r[4:3]) : (opt[2] ? 2'h0 : 2'h3);
      chk(net_sig, xn);
      chk(ringback_tone, opt[1] & r[6] & !r[5]);
      chk(port_cfg, exp_cfg());
      rd(8'h18, sd);
      chk(sd, {24'h0, r[5], opt[1] & r[6] & !r[5], 4'h1, xn});
    end
    @(posedge ref_clk);
    i_far.lines(1'b0, 1'b0);
    wr(8'h00, {21'h0, 3'(typ), 1'b0, 3'h2, 4'h1});
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h2);
    i_far.seize(3, dl, wd);
    chk(dl >= 2 * T + 2 && dl <= 3 * T + 2, 1'b1);
    chk(wd, 2 * T);
    wr(8'h04, 32'h1);
    i_far.seize(3, dl, wd);
    chk(dl >= 2 && dl <= T + 2, 1'b1);
    chk(wd, 2 * T);
    wr(8'h00, {21'h0, 3'(typ), 1'b0, 3'h0, 4'h1});
    i_far.seize(3, dl, wd);
    chk(wd, 0);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(net_sig, 2'h0);
    chk_regs();
    finish_test();
  end

endmodule : voice_port_signaling_control_tb_top
